// file: src/fog_pkg.sv
// constants and types shared by the fanout output gating block
package fog_pkg;

  // output count and the range that owns a hardware enable pin
  localparam int NUM_OUT = 20;
  localparam int PIN_LO = 5;
  localparam int PIN_HI = 12;
  localparam int NUM_PIN = 8;

  // wishbone byte offsets
  localparam logic [3:0] REG_SW_ENABLE = 4'h0;
  localparam logic [3:0] REG_PIN_LEVEL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_GATE = 4'hc;

  // reset values
  localparam logic [19:0] SW_ENABLE_RESET = 20'hfffff;

  // status register bit positions
  localparam int ST_GOOD_SEEN = 0;
  localparam int ST_SAVING = 1;
  localparam int ST_STABLE = 2;
  localparam int ST_LATE = 3;
  localparam int ST_ADDR_LO = 4;
  localparam int ST_ADDR_HI = 6;

  // timing: output periods still delivered after a stop request
  localparam logic [2:0] STOP_PERIODS = 3'h4;
  // complement rising edges with the request low before power-down is taken
  localparam logic [1:0] PD_SAMPLES = 2'h2;
  // longest time from power good to stable clocks, and its cycle count
  localparam int SYS_CLK_MHZ = 125;
  localparam int STABLE_TIME_US = 1800;
  localparam int STABLE_CYCLES = STABLE_TIME_US * SYS_CLK_MHZ;

  // power pin interpretation
  typedef enum logic [1:0] {
    PWR_WAIT_GOOD,
    PWR_RUN,
    PWR_DOWN
  } fog_power_type;

endpackage

// file: src/fog_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module fog_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] asyncIn, // levels from pins
  output logic [WIDTH-1:0] syncOut // levels in the sys_clk domain
);

  logic [WIDTH-1:0] firstStage;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      firstStage <= '0;
      syncOut <= '0;
    end else begin
      firstStage <= asyncIn;
      syncOut <= firstStage;
    end
  end

endmodule

// file: src/fog_output_gating.sv
// output enable and power-down gating for a twenty output clock fanout
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// - each of twenty outputs individually enabled
// - enable pins asynchronous, low means run
// - software enable bits active high, reset enabled
// - pins exist only for outputs five to twelve
// - pinned output runs when bit 1, pin 0
// - other outputs run on power good and bit
// - disabled output drives both legs low
// - pin fall resumes output within ten periods
// - pin rise still delivers four clean cycles
// - pin rise disables within ten periods
// - power pin low disables every output
// - first power good rise captures configuration
// - later power pin low is power-down request
// - power-down request taken synchronously
// - release restarts enabled outputs cleanly
// - two complement rises low, stop at fall
// - stable clocks within 1.8 ms of power good
module fog_output_gating #(
  parameter int STABLE_CYCLES = fog_pkg::STABLE_CYCLES
) (
  input wire logic sys_clk, // reference clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] outputEnablePin_n, // hardware enables of outputs 12..5
  input wire logic power_good_or_down_pin, // power good, later power-down request low
  input wire logic [1:0] bus_addr_select_lo, // low address select level code
  input wire logic [1:0] bus_addr_select_hi, // high address select level code
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic [19:0] fanout_clock_out, // true legs
  output logic [19:0] fanout_clock_out_complement // complement legs
);

  typedef struct packed {
    fog_pkg::fog_power_type power;
    logic phase;
    logic [19:0] gate;
    logic [19:0][2:0] stopCount;
    logic [1:0] lowCount;
    logic [19:0] swEnable;
    logic [3:0] addrSel;
    logic goodSeen;
    logic stable;
    logic late;
    logic [17:0] stableCount;
    logic ack;
    logic [31:0] rdData;
    logic [19:0] trueOut;
    logic [19:0] compOut;
  } fog_state_type;

  fog_state_type s;
  fog_state_type next_s;

  logic [12:0] syncLevel;
  logic [7:0] pinLevel;
  logic powerPin;
  logic [3:0] addrLevel;
  logic busReq;

  // true when output index owns a hardware enable pin
  function automatic logic hasPin(input int idx);
    hasPin = (idx >= fog_pkg::PIN_LO) && (idx <= fog_pkg::PIN_HI);
  endfunction

  // run request of one output from its software bit and its pin
  function automatic logic wantRun(input int idx, input logic swBit,
                                   input logic [7:0] pins);
    logic pinOk;
    pinOk = 1'b1;
    if (hasPin(idx)) begin
      pinOk = ~pins[idx - fog_pkg::PIN_LO];
    end
    wantRun = swBit & pinOk;
  endfunction

  // all pins pass two flops before any logic reads them
  fog_sync #(
    .WIDTH(13)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({bus_addr_select_hi, bus_addr_select_lo, power_good_or_down_pin,
              outputEnablePin_n}),
    .syncOut(syncLevel)
  );

  // split synchronised levels
  assign pinLevel = syncLevel[7:0];
  assign powerPin = syncLevel[8];
  assign addrLevel = syncLevel[12:9];
  assign busReq = wb_cyc_i & wb_stb_i;

  // next state of the whole block
  always_comb begin
    logic runAllowed;
    logic updatePoint;
    logic [31:0] status;
    runAllowed = 1'b0;
    updatePoint = 1'b0;
    status = '0;
    next_s = s;

    // reference divided by two; update point is phase low to high
    next_s.phase = ~s.phase;
    updatePoint = ~s.phase;

    // power pin interpretation
    case (s.power)
      fog_pkg::PWR_WAIT_GOOD: begin
        if (powerPin) begin
          next_s.power = fog_pkg::PWR_RUN;
          next_s.goodSeen = 1'b1;
          next_s.addrSel = addrLevel;
          next_s.lowCount = '0;
        end
      end
      fog_pkg::PWR_RUN: begin
        // phase high to low is the complement rising edge
        if (s.phase) begin
          if (!powerPin) begin
            next_s.lowCount = s.lowCount + 2'h1;
            if (s.lowCount + 2'h1 >= fog_pkg::PD_SAMPLES) begin
              next_s.power = fog_pkg::PWR_DOWN;
            end
          end else begin
            next_s.lowCount = '0;
          end
        end
      end
      fog_pkg::PWR_DOWN: begin
        if (powerPin) begin
          next_s.power = fog_pkg::PWR_RUN;
          next_s.lowCount = '0;
        end
      end
      default: begin
        next_s.power = fog_pkg::PWR_WAIT_GOOD;
      end
    endcase

    // down state and waiting for power good both hold outputs off
    runAllowed = (s.power == fog_pkg::PWR_RUN);

    // per output gate changes only at the update point, true leg low
    for (int i = 0; i < fog_pkg::NUM_OUT; i++) begin
      if (updatePoint) begin
        if (!runAllowed) begin
          next_s.gate[i] = 1'b0;
          next_s.stopCount[i] = fog_pkg::STOP_PERIODS;
        end else if (wantRun(i, s.swEnable[i], pinLevel)) begin
          next_s.gate[i] = 1'b1;
          next_s.stopCount[i] = fog_pkg::STOP_PERIODS;
        end else if (s.gate[i] && s.stopCount[i] != 3'h0) begin
          next_s.stopCount[i] = s.stopCount[i] - 3'h1;
        end else begin
          next_s.gate[i] = 1'b0;
        end
      end
    end

    // stable once the first gate update in run has happened
    if (runAllowed && updatePoint) begin
      next_s.stable = 1'b1;
    end
    if (s.goodSeen && !s.stable && !s.late) begin
      next_s.stableCount = s.stableCount + 18'h1;
      if (s.stableCount >= 18'(STABLE_CYCLES - 1)) begin
        next_s.late = 1'b1;
      end
    end

    // disabled outputs drive both legs low
    next_s.trueOut = {20{next_s.phase}} & next_s.gate;
    next_s.compOut = {20{~next_s.phase}} & next_s.gate;

    // status word
    status[fog_pkg::ST_GOOD_SEEN] = s.goodSeen;
    status[fog_pkg::ST_SAVING] = (s.power == fog_pkg::PWR_DOWN);
    status[fog_pkg::ST_STABLE] = s.stable;
    status[fog_pkg::ST_LATE] = s.late;
    status[fog_pkg::ST_ADDR_LO +: 2] = s.addrSel[1:0];
    status[fog_pkg::ST_ADDR_HI +: 2] = s.addrSel[3:2];

    // wishbone slave: one wait state, ack drops after one cycle
    next_s.ack = busReq & ~s.ack;
    if (busReq && !s.ack) begin
      next_s.rdData = '0;
      if (wb_we_i) begin
        if (wb_adr_i == fog_pkg::REG_SW_ENABLE) begin
          if (wb_sel_i[0]) begin
            next_s.swEnable[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_s.swEnable[15:8] = wb_dat_i[15:8];
          end
          if (wb_sel_i[2]) begin
            next_s.swEnable[19:16] = wb_dat_i[19:16];
          end
        end
      end else begin
        case (wb_adr_i)
          fog_pkg::REG_SW_ENABLE: next_s.rdData = {12'h000, s.swEnable};
          fog_pkg::REG_PIN_LEVEL: next_s.rdData = {24'h000000, pinLevel};
          fog_pkg::REG_STATUS: next_s.rdData = status;
          fog_pkg::REG_GATE: next_s.rdData = {12'h000, s.gate};
          default: next_s.rdData = '0;
        endcase
      end
    end
  end

  // register the whole state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.power <= fog_pkg::PWR_WAIT_GOOD;
      s.phase <= 1'b0;
      s.gate <= '0;
      s.stopCount <= {20{fog_pkg::STOP_PERIODS}};
      s.lowCount <= '0;
      s.swEnable <= fog_pkg::SW_ENABLE_RESET;
      s.addrSel <= '0;
      s.goodSeen <= 1'b0;
      s.stable <= 1'b0;
      s.late <= 1'b0;
      s.stableCount <= '0;
      s.ack <= 1'b0;
      s.rdData <= '0;
      s.trueOut <= '0;
      s.compOut <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign fanout_clock_out = s.trueOut;
  assign fanout_clock_out_complement = s.compOut;
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdData;

endmodule

// file: bench/fog_monitor.sv
// assertion checker for the fanout output gating block
`timescale 1ns/1ps
module fog_monitor (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic [7:0] outputEnablePin_n, // pins
  input wire logic power_good_or_down_pin, // power pin
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [3:0] wb_adr_i, // address
  input wire logic wb_ack_o, // ack
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic [19:0] fanout_clock_out, // true legs
  input wire logic [19:0] fanout_clock_out_complement // comp legs
);
  logic [4:0] lowCnt;
  logic [4:0] hiCnt;
  logic req;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // saturating counts of power pin low and all pins high
  always_ff @(posedge sys_clk) begin
    lowCnt <= (rst || power_good_or_down_pin) ? 5'h0 : lowCnt + {4'h0, lowCnt != 5'h1f};
    hiCnt <= (rst || !(&outputEnablePin_n)) ? 5'h0 : hiCnt + {4'h0, hiCnt != 5'h1f};
  end
  property p_apart; (fanout_clock_out & fanout_clock_out_complement) == 20'h0; endproperty
  a_apart: assert property (p_apart) else $error("both legs high");
  property p_short; (fanout_clock_out & $past(fanout_clock_out)) == 20'h0; endproperty
  a_short: assert property (p_short) else $error("high phase too long");
  property p_ack; req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_hole; req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_down; lowCnt >= 5'd16 |-> (fanout_clock_out | fanout_clock_out_complement) == 20'h0;
  endproperty
  a_down: assert property (p_down) else $error("output runs in power-down");
  property p_pins;
    hiCnt >= 5'd22 |-> (fanout_clock_out[12:5] | fanout_clock_out_complement[12:5]) == 8'h0;
  endproperty
  a_pins: assert property (p_pins) else $error("pinned output not stopped");
  c_read: cover property (req && !wb_we_i);
  c_run: cover property (&(fanout_clock_out | fanout_clock_out_complement));
  c_down: cover property (lowCnt == 5'd16);
endmodule
bind fog_output_gating fog_monitor mon (.sys_clk(sys_clk), .rst(rst),
  .outputEnablePin_n(outputEnablePin_n), .power_good_or_down_pin(power_good_or_down_pin),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .fanout_clock_out(fanout_clock_out),
  .fanout_clock_out_complement(fanout_clock_out_complement));

// file: bench/fog_board_model.sv
// board control logic driving the enable and power pins
`timescale 1ns/1ps
module fog_board_model (
  input wire logic [7:0] pinCmd, // wanted pin levels
  input wire logic pwrCmd, // wanted power level
  input wire logic [3:0] addrCmd, // wanted select codes
  output logic [7:0] outputEnablePin_n = 8'hff, // enable pins
  output logic power_good_or_down_pin = 1'b0, // power pin, low at start
  output logic [1:0] bus_addr_select_lo = 2'h0, // low select
  output logic [1:0] bus_addr_select_hi = 2'h0 // high select
);
  // pins move off the clock edge, unrelated to it
  always @(pinCmd) outputEnablePin_n <= #3 pinCmd;
  // power-down requested only while the reference clock keeps running
  always @(pwrCmd) power_good_or_down_pin <= #5 pwrCmd;
  // select levels settle before power good rises
  always @(addrCmd) {bus_addr_select_hi, bus_addr_select_lo} <= #1 addrCmd;
endmodule

// file: bench/fog_output_gating_test.sv
// self-checking bench for the fanout output gating block
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmpCount++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module fog_output_gating_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, pwrCmd = 1'b0, pwrL, ack;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0, addrCmd = 4'h0;
  logic [31:0] wbDat = 32'h0, seed = 32'hd5fc0e7d, datO;
  logic [7:0] pinCmd = 8'hff, pinL;
  logic [1:0] selLo, selHi;
  logic [19:0] sw = 20'hfffff, ckT, ckC;
  logic [63:0] rdQ[$];
  logic [19:0] actQ[$];
  int miscompares = 0, cmpCount = 0, cycles = 0;
  event probe;
  always #4 sys_clk = ~sys_clk;
  fog_board_model board (.pinCmd(pinCmd), .pwrCmd(pwrCmd), .addrCmd(addrCmd),
    .outputEnablePin_n(pinL), .power_good_or_down_pin(pwrL), .bus_addr_select_lo(selLo),
    .bus_addr_select_hi(selHi));
  fog_output_gating #(.STABLE_CYCLES(50)) uut (.sys_clk(sys_clk), .rst(rst),
    .outputEnablePin_n(pinL), .power_good_or_down_pin(pwrL), .bus_addr_select_lo(selLo),
    .bus_addr_select_hi(selHi), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ack),
    .fanout_clock_out(ckT), .fanout_clock_out_complement(ckC));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle; a read leaves its masked expectation in the queue
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, input logic [31:0] msk);
    int n;
    n = 0;
    if (!we) rdQ.push_back({msk, dat & msk});
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= dat;
    do @(posedge sys_clk); while (ack !== 1'b1 && n++ < 99);
    // a slave that never answers counts against the run
    if (ack !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED bus ack expected 1 seen %b", ack);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  // let gating settle, then note which outputs should toggle
  task automatic check();
    repeat (30) @(posedge sys_clk);
    actQ.push_back(pwrCmd ? sw & ~{7'h0, pinCmd, 5'h0} : 20'h0);
    ->probe;
    repeat (8) @(posedge sys_clk);
  endtask
  // release one pin: count delivered pulses, then pull it low and time the restart
  task automatic tail(input int k);
    int hi, t;
    hi = 0;
    t = 0;
    pinCmd[k] <= 1'b1;
    repeat (30) begin
      @(posedge sys_clk);
      hi += ckT[k+5];
    end
    `CHK("tail pulses", 1'b1, hi >= 4 && hi <= 11)
    pinCmd[k] <= 1'b0;
    do @(posedge sys_clk); while (ckT[k+5] !== 1'b1 && t++ < 40);
    `CHK("restart delay", 1'b1, t <= 21)
  endtask
  // read data watcher
  always @(posedge sys_clk) if (ack === 1'b1 && !wbWe && rdQ.size() > 0) begin
    logic [63:0] e;
    e = rdQ.pop_front();
    `CHK("read data", e[31:0], datO & e[63:32])
  end
  // output activity watcher: any leg high over three periods
  always @(probe) begin
    logic [19:0] seen, e;
    seen = 20'h0;
    e = actQ.pop_front();
    repeat (6) begin
      @(posedge sys_clk);
      seen = seen | ckT | ckC;
    end
    `CHK("activity", e, seen)
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wb(0, 4'h0, 4'hf, 32'h000fffff, '1);
    wb(0, 4'h2, 4'hf, 32'h0, '1);
    check();
    $display("test reset done");
    seed = lfsr(seed);
    addrCmd <= seed[3:0];
    pinCmd <= seed[11:4];
    repeat (4) @(posedge sys_clk);
    pwrCmd <= 1'b1;
    check();
    addrCmd <= ~seed[3:0];
    wb(0, 4'h8, 4'hf, {24'h0, seed[3:0], 4'h1}, 32'hfffffff3);
    wb(0, 4'h4, 4'hf, {24'h0, pinCmd}, '1);
    $display("test power good done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pinCmd <= seed[27:20];
      wb(1, 4'h0, seed[31:28], {12'h0, seed[19:0]}, '0);
      if (seed[28]) sw[7:0] = seed[7:0];
      if (seed[29]) sw[15:8] = seed[15:8];
      if (seed[30]) sw[19:16] = seed[19:16];
      wb(0, 4'h0, 4'hf, {12'h0, sw}, '1);
      check();
    end
    $display("test enables done");
    sw = 20'hfffff;
    pinCmd <= 8'h0;
    wb(1, 4'h0, 4'hf, 32'h000fffff, '0);
    check();
    tail(0);
    tail(7);
    $display("test pin tail done");
    pwrCmd <= 1'b0;
    check();
    wb(0, 4'h8, 4'hf, 32'h2, 32'h2);
    pwrCmd <= 1'b1;
    check();
    $display("test power-down done");
    conclude();
  end
endmodule
